//--- design/cmp_ctrl_pkg.sv
// Constants, field layouts and types for the analog comparator control block.
// Assumes a 32-bit AXI4-Lite register port and one system clock.
package cmp_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int LEVEL_W = 10;
  localparam int CHAN_N = 8;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CSR = 10'h050;
  localparam logic [9:0] IDX_CONV_B = 10'h07B;
  localparam logic [9:0] IDX_DIDR = 10'h07E;
  // comparator_control_status fields
  localparam int CSR_PWR_OFF = 7;
  localparam int CSR_BANDGAP = 6;
  localparam int CSR_OUT = 5;
  localparam int CSR_FLAG = 4;
  localparam int CSR_IE = 3;
  localparam int CSR_CAPT = 2;
  localparam int CSR_MODE_HI = 1;
  localparam int CSR_MODE_LO = 0;
  // converter_control_b fields
  localparam int CONVB_MUX_EN = 6;
  localparam int CONVB_TRIG_HI = 2;
  localparam int CONVB_TRIG_LO = 0;
  // digital_input_disable_one fields
  localparam int DIDR_POS = 0;
  localparam int DIDR_NEG = 1;
  // Bandgap level in the same units as the pin levels (plain default)
  localparam logic [LEVEL_W-1:0] BANDGAP_LEVEL = 10'h0E1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } event_mode_e;

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_e;

  // Software-owned control fields of comparator_control_status
  typedef struct packed {
    logic power_off;
    logic bandgap;
    logic irq_en;
    logic capture;
    event_mode_e mode;
  } csr_ctl_s;
endpackage

//--- design/analog_comparator_control.sv
// Digital control around an analog comparator: input selection, output
// synchroniser, event flag and interrupt, capture routing, pin buffers.
// Assumes converter state arrives on aclk; pin levels are sampled words.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - Raw result is high when selected positive level exceeds selected negative.
// - Raw result is synchronised into the output status bit, two-cycle latency.
// - Mux enabled and converter off: channel select picks channel pin 0 to 7.
// - Mux disabled or converter on: dedicated negative pin is used.
// - Bandgap select chooses bandgap reference, else dedicated positive pin.
// - Power-off bit switches comparator off at any time; zero re-enables.
// - Mode field: 00 toggle, 01 reserved, 10 falling, 11 rising edge.
// - Matching output event sets the flag regardless of interrupt enable.
// - Flag clears when the processor executes the comparator vector.
// - Writing one to the flag clears it; zero leaves it.
// - Interrupt asserted while flag, enable and global enable are set.
// - Capture-route bit feeds the output to timer capture front end.
// - Capture-route bit zero disconnects the output from timer capture.
// - Input-disable bit turns off pin buffer; pin read returns zero.
// - Converter-on bit blocks the multiplexed negative input path.
module analog_comparator_control (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [cmp_ctrl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [cmp_ctrl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog levels
  input wire logic [cmp_ctrl_pkg::LEVEL_W-1:0] pos_input_pin,
  input wire logic [cmp_ctrl_pkg::LEVEL_W-1:0] neg_input_pin,
  input wire logic [cmp_ctrl_pkg::CHAN_N-1:0][cmp_ctrl_pkg::LEVEL_W-1:0] analog_channel_pins,
  // Converter state, same clock
  input wire logic converter_on,
  input wire logic [2:0] channel_select,
  // Digital pin buffers
  input wire logic pos_pin_din,
  input wire logic neg_pin_din,
  output logic pos_pin_read,
  output logic neg_pin_read,
  output logic [1:0] pin_buffer_off,
  // Processor side
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic cmp_irq,
  // Analog and timer side
  output logic cmp_power_off,
  output logic bandgap_pos_select,
  output logic capture_trigger
);
  import cmp_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  csr_ctl_s ctl_r, ctl_nxt;
  logic flag_r, flag_nxt;
  logic mux_en_r, mux_en_nxt;
  logic [2:0] trig_r, trig_nxt;
  logic [1:0] didr_r, didr_nxt;
  logic sync1_r, out_sync_r, prev_r;
  logic pos_s1_r, pos_s2_r, neg_s1_r, neg_s2_r;
  logic pos_read_r, neg_read_r, pos_read_nxt, neg_read_nxt;
  logic irq_r, irq_nxt, capt_r, capt_nxt;
  logic [LEVEL_W-1:0] pos_level, neg_level;
  logic cmp_raw, event_hit, csr_w1c;
  wr_state_e wr_r, wr_nxt;
  rd_state_e rd_r, rd_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic w_lane0_r, w_lane0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write;

  ////////////////////////////////////////////////////////////////////////
  // Analog input selection and comparison
  always_comb begin
    // Converter owns the mux while on, so the shared path falls back
    if (mux_en_r && !converter_on) begin
      neg_level = analog_channel_pins[channel_select];
    end else begin
      neg_level = neg_input_pin;
    end
    pos_level = ctl_r.bandgap ? BANDGAP_LEVEL : pos_input_pin;
    // A powered-off comparator reads low
    cmp_raw = !ctl_r.power_off && (pos_level > neg_level);
  end

  ////////////////////////////////////////////////////////////////////////
  // Event detection on the synchronised output
  always_comb begin
    case (ctl_r.mode)
      MODE_TOGGLE: event_hit = out_sync_r ^ prev_r;
      MODE_FALL: event_hit = prev_r && !out_sync_r;
      MODE_RISE: event_hit = out_sync_r && !prev_r;
      default: event_hit = 1'b0;
    endcase
  end

  // Synchronisers: only the second stage feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      out_sync_r <= 1'b0;
      prev_r <= 1'b0;
      pos_s1_r <= 1'b0;
      pos_s2_r <= 1'b0;
      neg_s1_r <= 1'b0;
      neg_s2_r <= 1'b0;
    end else begin
      sync1_r <= cmp_raw;
      out_sync_r <= sync1_r;
      prev_r <= out_sync_r;
      pos_s1_r <= pos_pin_din;
      pos_s2_r <= pos_s1_r;
      neg_s1_r <= neg_pin_din;
      neg_s2_r <= neg_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read channels
  always_comb begin
    wr_nxt = wr_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    do_write = 1'b0;
    case (wr_r)
      WR_IDLE: begin
        if (awvalid && awready_r) begin
          aw_have_nxt = 1'b1;
          aw_addr_nxt = awaddr;
        end
        if (wvalid && wready_r) begin
          w_have_nxt = 1'b1;
          w_data_nxt = wdata;
          w_lane0_nxt = wstrb[0];
        end
        // Address and data may arrive in either order
        if (aw_have_r && w_have_r) begin
          do_write = 1'b1;
          aw_have_nxt = 1'b0;
          w_have_nxt = 1'b0;
          bvalid_nxt = 1'b1;
          wr_nxt = WR_RESP;
          if (aw_addr_r == {IDX_CSR, 2'b00} || aw_addr_r == {IDX_CONV_B, 2'b00}
              || aw_addr_r == {IDX_DIDR, 2'b00}) begin
            bresp_nxt = RESP_OKAY;
          end else begin
            bresp_nxt = RESP_SLVERR;
          end
        end
      end
      WR_RESP: begin
        if (bready) begin
          bvalid_nxt = 1'b0;
          wr_nxt = WR_IDLE;
        end
      end
      default: wr_nxt = WR_IDLE;
    endcase
    awready_nxt = (wr_nxt == WR_IDLE) && !aw_have_nxt;
    wready_nxt = (wr_nxt == WR_IDLE) && !w_have_nxt;
  end

  // Read data is captured at acceptance and held until taken
  always_comb begin
    rd_nxt = rd_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    case (rd_r)
      RD_IDLE: begin
        if (arvalid && arready_r) begin
          rvalid_nxt = 1'b1;
          rd_nxt = RD_DATA;
          rresp_nxt = RESP_OKAY;
          rdata_nxt = ZERO_WORD;
          if (araddr == {IDX_CSR, 2'b00}) begin
            rdata_nxt[CSR_PWR_OFF] = ctl_r.power_off;
            rdata_nxt[CSR_BANDGAP] = ctl_r.bandgap;
            rdata_nxt[CSR_OUT] = out_sync_r;
            rdata_nxt[CSR_FLAG] = flag_r;
            rdata_nxt[CSR_IE] = ctl_r.irq_en;
            rdata_nxt[CSR_CAPT] = ctl_r.capture;
            rdata_nxt[CSR_MODE_HI:CSR_MODE_LO] = ctl_r.mode;
          end else if (araddr == {IDX_CONV_B, 2'b00}) begin
            rdata_nxt[CONVB_MUX_EN] = mux_en_r;
            rdata_nxt[CONVB_TRIG_HI:CONVB_TRIG_LO] = trig_r;
          end else if (araddr == {IDX_DIDR, 2'b00}) begin
            rdata_nxt[DIDR_NEG:DIDR_POS] = didr_r;
          end else begin
            rresp_nxt = RESP_SLVERR;
          end
        end
      end
      RD_DATA: begin
        if (rready) begin
          rvalid_nxt = 1'b0;
          rd_nxt = RD_IDLE;
        end
      end
      default: rd_nxt = RD_IDLE;
    endcase
    arready_nxt = (rd_nxt == RD_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file, flag and outputs
  always_comb begin
    ctl_nxt = ctl_r;
    mux_en_nxt = mux_en_r;
    trig_nxt = trig_r;
    didr_nxt = didr_r;
    csr_w1c = 1'b0;
    // Only byte lane 0 carries register bits
    if (do_write && w_lane0_r) begin
      if (aw_addr_r == {IDX_CSR, 2'b00}) begin
        ctl_nxt.power_off = w_data_r[CSR_PWR_OFF];
        ctl_nxt.bandgap = w_data_r[CSR_BANDGAP];
        ctl_nxt.irq_en = w_data_r[CSR_IE];
        ctl_nxt.capture = w_data_r[CSR_CAPT];
        ctl_nxt.mode = event_mode_e'(w_data_r[CSR_MODE_HI:CSR_MODE_LO]);
        csr_w1c = w_data_r[CSR_FLAG];
      end else if (aw_addr_r == {IDX_CONV_B, 2'b00}) begin
        mux_en_nxt = w_data_r[CONVB_MUX_EN];
        trig_nxt = w_data_r[CONVB_TRIG_HI:CONVB_TRIG_LO];
      end else if (aw_addr_r == {IDX_DIDR, 2'b00}) begin
        didr_nxt = w_data_r[DIDR_NEG:DIDR_POS];
      end
    end
    // Clears first so a same-cycle event still sets the flag
    flag_nxt = flag_r;
    if (csr_w1c || irq_vector_ack) begin
      flag_nxt = 1'b0;
    end
    if (event_hit) begin
      flag_nxt = 1'b1;
    end
    // Mode or power changes with the enable set can fire spuriously
    irq_nxt = flag_nxt && ctl_nxt.irq_en && global_irq_enable;
    capt_nxt = ctl_nxt.capture && out_sync_r;
    pos_read_nxt = pos_s2_r && !didr_nxt[DIDR_POS];
    neg_read_nxt = neg_s2_r && !didr_nxt[DIDR_NEG];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= '0;
      flag_r <= 1'b0;
      mux_en_r <= 1'b0;
      trig_r <= 3'h0;
      didr_r <= 2'h0;
      irq_r <= 1'b0;
      capt_r <= 1'b0;
      pos_read_r <= 1'b0;
      neg_read_r <= 1'b0;
      wr_r <= WR_IDLE;
      rd_r <= RD_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= ZERO_WORD;
      w_lane0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= ZERO_WORD;
    end else begin
      ctl_r <= ctl_nxt;
      flag_r <= flag_nxt;
      mux_en_r <= mux_en_nxt;
      trig_r <= trig_nxt;
      didr_r <= didr_nxt;
      irq_r <= irq_nxt;
      capt_r <= capt_nxt;
      pos_read_r <= pos_read_nxt;
      neg_read_r <= neg_read_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign cmp_irq = irq_r;
  assign capture_trigger = capt_r;
  assign pos_pin_read = pos_read_r;
  assign neg_pin_read = neg_read_r;
  assign pin_buffer_off = didr_r;
  assign cmp_power_off = ctl_r.power_off;
  assign bandgap_pos_select = ctl_r.bandgap;

  ////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_raw_compare: assert property (
    (!ctl_r.power_off && pos_level > neg_level) |-> ##2 out_sync_r)
    else $error("output did not follow a positive comparison");
  a_sync_latency: assert property (out_sync_r == $past(cmp_raw, 2))
    else $error("synchronised output latency wrong");
  a_mux_channel: assert property (
    (mux_en_r && !converter_on) |-> neg_level == analog_channel_pins[channel_select])
    else $error("channel pin not selected as negative input");
  a_neg_pin_path: assert property (
    (!mux_en_r || converter_on) |-> neg_level == neg_input_pin)
    else $error("dedicated negative pin not selected");
  a_bandgap_path: assert property (
    pos_level == (ctl_r.bandgap ? BANDGAP_LEVEL : pos_input_pin))
    else $error("positive input selection wrong");
  a_power_off_low: assert property (ctl_r.power_off [*3] |-> !out_sync_r)
    else $error("output high while comparator off");
  a_fall_mode: assert property (
    (ctl_r.mode == MODE_FALL && prev_r && !out_sync_r) |=> flag_r)
    else $error("falling edge did not set flag");
  a_event_sets: assert property (event_hit |=> flag_r)
    else $error("event lost");
  a_vector_clear: assert property ((irq_vector_ack && !event_hit) |=> !flag_r)
    else $error("vector did not clear flag");
  a_flag_hold: assert property (
    (flag_r && !irq_vector_ack && !(do_write && w_lane0_r
      && aw_addr_r == {IDX_CSR, 2'b00} && w_data_r[CSR_FLAG])) |=> flag_r)
    else $error("flag cleared without cause");
  a_irq_gate: assert property (
    cmp_irq |-> (flag_r && ctl_r.irq_en && $past(global_irq_enable)))
    else $error("interrupt without flag, enable and global enable");
  a_capture_on: assert property (
    ctl_r.capture |-> capture_trigger == $past(out_sync_r))
    else $error("capture path not following output");
  a_capture_off: assert property (!ctl_r.capture |-> !capture_trigger)
    else $error("capture path active while unrouted");
  a_buffer_off: assert property (didr_r[DIDR_POS] |-> !pos_pin_read)
    else $error("disabled buffer read nonzero");
  a_reserved_mode: assert property (ctl_r.mode == MODE_RSVD |-> !event_hit)
    else $error("reserved mode raised an event");
  a_edge_once: assert property (event_hit |-> out_sync_r != prev_r)
    else $error("event without a transition");

  c_rise_flag: cover property (ctl_r.mode == MODE_RISE && event_hit);
  c_irq_fires: cover property (!cmp_irq ##1 cmp_irq);
  c_mux_path: cover property (mux_en_r && !converter_on && out_sync_r);
  c_set_wins: cover property (event_hit && irq_vector_ack);
endmodule // analog_comparator_control

//--- testbench/analog_front_model.sv
// Far-side model: analog levels and digital pin inputs at the comparator,
// plus a timer capture front end counting rising edges it is routed.
// Assumes tasks are called from the aclk domain of the bench.
`timescale 1ns/1ps
module analog_front_model (
  // Clock
  input wire logic aclk,
  // Levels and pins towards the block
  output logic [cmp_ctrl_pkg::LEVEL_W-1:0] pos_level,
  output logic [cmp_ctrl_pkg::LEVEL_W-1:0] neg_level,
  output logic [cmp_ctrl_pkg::CHAN_N-1:0][cmp_ctrl_pkg::LEVEL_W-1:0] chan_level,
  output logic pos_din,
  output logic neg_din,
  // Timer capture side
  input wire logic capture_trigger
);
  import cmp_ctrl_pkg::*;
  int capture_edges;
  logic trig_q;
  ////////////////////////////////////////////////////////////////////////
  // Everything low at start, so the raw compare is low too
  initial begin
    pos_level = '0;
    neg_level = '0;
    chan_level = '0;
    pos_din = 1'b0;
    neg_din = 1'b0;
    capture_edges = 0;
    trig_q = 1'b0;
  end
  // Edge select of the capture front end; a level held high counts once
  always @(posedge aclk) begin
    trig_q <= capture_trigger;
    if (capture_trigger && !trig_q) capture_edges <= capture_edges + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  // Levels change just after an edge, like any other input
  task automatic set_levels(input logic [LEVEL_W-1:0] p, n,
                            input logic [CHAN_N-1:0][LEVEL_W-1:0] c);
    @(posedge aclk);
    pos_level <= p;
    neg_level <= n;
    chan_level <= c;
  endtask
  task automatic set_din(input logic p, n);
    @(posedge aclk);
    pos_din <= p;
    neg_din <= n;
  endtask
endmodule // analog_front_model

//--- testbench/analog_comparator_control_tb.sv
// Self-checking bench for the comparator control block over AXI4-Lite.
// Assumes the far-side model drives every analog level and pin input.
`timescale 1ns/1ps
module analog_comparator_control_tb;
  import cmp_ctrl_pkg::*;
  localparam logic [11:0] A_CSR = 12'h140;
  localparam logic [11:0] A_CNV = 12'h1EC;
  localparam logic [11:0] A_DID = 12'h1F8;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, converter_on, pos_pin_din, neg_pin_din;
  logic pos_pin_read, neg_pin_read, global_irq_enable, irq_vector_ack, cmp_irq;
  logic cmp_power_off, bandgap_pos_select, capture_trigger;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [2:0] channel_select;
  logic [1:0] bresp, rresp, rsp, pin_buffer_off;
  logic [LEVEL_W-1:0] pos_input_pin, neg_input_pin;
  logic [CHAN_N-1:0][LEVEL_W-1:0] analog_channel_pins;
  int bad_count, checks;
  ////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  analog_comparator_control u_analog_comparator_control (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pos_input_pin, .neg_input_pin, .analog_channel_pins, .converter_on,
    .channel_select, .pos_pin_din, .neg_pin_din, .pos_pin_read, .neg_pin_read,
    .pin_buffer_off, .global_irq_enable, .irq_vector_ack, .cmp_irq, .cmp_power_off,
    .bandgap_pos_select, .capture_trigger);
  analog_front_model u_analog_front_model (
    .aclk, .pos_level(pos_input_pin), .neg_level(neg_input_pin),
    .chan_level(analog_channel_pins), .pos_din(pos_pin_din), .neg_din(neg_pin_din),
    .capture_trigger);
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] got, exp, input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // AXI4-Lite write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  // AXI4-Lite read
  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // Let the synchroniser settle, then read one status bit
  task automatic chk_bit(input int b, input logic e, input string msg);
    repeat (4) @(posedge aclk);
    rd_reg(A_CSR);
    check(32'(rd[b]), 32'(e), msg);
  endtask
  task automatic levels(input logic [LEVEL_W-1:0] p, n);
    u_analog_front_model.set_levels(p, n, '0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values, read-only bits, unmapped addresses
  task automatic t_regs();
    rd_reg(A_CSR);
    check(rd, 32'h0, "csr reset");
    rd_reg(A_DID);
    check(rd, 32'h0, "didr reset");
    rd_reg(12'h004);
    check({rd[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(12'h004, 32'hFF);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    wr(A_CNV, 32'hFFFF_FFFF);
    rd_reg(A_CNV);
    check(rd, 32'h47, "conv_b mask");
  endtask
  // Negative input sweep over every channel, then the blocking conditions
  task automatic t_select();
    logic [CHAN_N-1:0][LEVEL_W-1:0] c;
    for (int k = 0; k < CHAN_N; k++) begin
      c = {CHAN_N{10'h3FF}};
      c[k] = 10'h050;
      channel_select <= k[2:0];
      u_analog_front_model.set_levels(10'h100, 10'h3FF, c);
      chk_bit(CSR_OUT, 1'b1, "channel pick");
    end
    converter_on <= 1'b1;
    chk_bit(CSR_OUT, 1'b0, "converter on");
    converter_on <= 1'b0;
    wr(A_CNV, 32'h0);
    chk_bit(CSR_OUT, 1'b0, "mux off");
  endtask
  // Bandgap against the boundary, power off and back on
  task automatic t_bandgap_power();
    levels(10'h000, BANDGAP_LEVEL - 10'h001);
    chk_bit(CSR_OUT, 1'b0, "pin positive");
    wr(A_CSR, 32'h40);
    chk_bit(CSR_OUT, 1'b1, "bandgap above");
    check(32'(bandgap_pos_select), 32'h1, "bandgap select");
    levels(10'h000, BANDGAP_LEVEL);
    chk_bit(CSR_OUT, 1'b0, "bandgap equal");
    wr(A_CSR, 32'h0);
    levels(10'h200, 10'h100);
    chk_bit(CSR_OUT, 1'b1, "powered");
    wr(A_CSR, 32'h80);
    chk_bit(CSR_OUT, 1'b0, "powered off");
    check(32'(cmp_power_off), 32'h1, "power pin");
    wr(A_CSR, 32'h0);
    chk_bit(CSR_OUT, 1'b1, "power back");
  endtask
  // Every event mode against one rise and one fall, enable kept clear
  task automatic t_events();
    for (int m = 0; m < 4; m++) begin
      wr(A_CSR, 32'(m));
      levels(10'h000, 10'h100);
      repeat (4) @(posedge aclk);
      wr(A_CSR, 32'h10 | 32'(m));
      levels(10'h200, 10'h100);
      chk_bit(CSR_FLAG, m == 0 || m == 3, "rise event");
      wr(A_CSR, 32'h10 | 32'(m));
      chk_bit(CSR_FLAG, 1'b0, "set once");
      levels(10'h000, 10'h100);
      chk_bit(CSR_FLAG, m == 0 || m == 2, "fall event");
    end
  endtask
  // Interrupt masking by both enables, write-zero, vector clear
  task automatic t_irq();
    wr(A_CSR, 32'h13);
    wr(A_CSR, 32'h0B);
    global_irq_enable <= 1'b1;
    levels(10'h200, 10'h100);
    chk_bit(CSR_FLAG, 1'b1, "flag set");
    check(32'(cmp_irq), 32'h1, "irq on");
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge aclk);
    check(32'(cmp_irq), 32'h0, "global mask");
    wr(A_CSR, 32'h03);
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'(cmp_irq), 32'h0, "enable mask");
    wr(A_CSR, 32'h0B);
    chk_bit(CSR_FLAG, 1'b1, "write zero");
    check(32'(cmp_irq), 32'h1, "irq back");
    irq_vector_ack <= 1'b1;
    @(posedge aclk);
    irq_vector_ack <= 1'b0;
    chk_bit(CSR_FLAG, 1'b0, "vector clear");
    check(32'(cmp_irq), 32'h0, "irq gone");
    wr(A_CSR, 32'h03);
  endtask
  // Capture routing off, then on with one fresh rising edge
  task automatic t_capture();
    int e0;
    e0 = u_analog_front_model.capture_edges;
    levels(10'h000, 10'h100);
    levels(10'h200, 10'h100);
    chk_bit(CSR_OUT, 1'b1, "out high");
    check(32'(capture_trigger), 32'h0, "unrouted");
    check(32'(u_analog_front_model.capture_edges - e0), 32'h0, "no edges");
    // Output low before routing, so enabling the path makes no edge of its own
    levels(10'h000, 10'h100);
    chk_bit(CSR_OUT, 1'b0, "out low");
    wr(A_CSR, 32'h04);
    levels(10'h200, 10'h100);
    chk_bit(CSR_OUT, 1'b1, "out again");
    check(32'(capture_trigger), 32'h1, "routed");
    check(32'(u_analog_front_model.capture_edges - e0), 32'h1, "one edge");
  endtask
  // Pin buffers: every disable pattern against pins held high
  task automatic t_pins();
    logic [1:0] d;
    u_analog_front_model.set_din(1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = k[1:0];
      wr(A_DID, 32'(d));
      repeat (4) @(posedge aclk);
      check(32'({neg_pin_read, pos_pin_read}), 32'(d ^ 2'b11), "pin read");
      check(32'(pin_buffer_off), 32'(d), "buffer off");
      rd_reg(A_DID);
      check(rd, 32'(d), "didr readback");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, converter_on} = '0;
    {global_irq_enable, irq_vector_ack, awaddr, araddr, wdata, channel_select} = '0;
    wstrb = 4'hF;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_select();
    t_bandgap_power();
    t_events();
    t_irq();
    t_capture();
    t_pins();
    end_of_test();
  end
  // Watchdog, well above the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // analog_comparator_control_tb
